/* File: hdl/aie_core.v */
// Add instruction execution unit with an Avalon-MM register slave.
`timescale 1ns/10ps
`include "aie_defs.vh"

module aie_core (
    input  wire        CLK,
    input  wire        RST,
    input  wire        INSTR_VALID,
    input  wire [15:0] INSTR,
    output reg  [1:0]  QUARTER,
    output reg         EXEC_DONE,
    output reg  [11:0] DMEM_ADDR,
    output reg         DMEM_RD,
    input  wire [7:0]  DMEM_RDATA,
    output reg         DMEM_WR,
    output reg  [7:0]  DMEM_WDATA,
    input  wire [7:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST
);

    reg  [7:0]  acc_reg;
    reg  [4:0]  flags_reg;
    reg  [3:0]  bank_reg;
    reg         ext_reg;
    reg  [11:0] idxbase_reg;
    reg         busy_reg;
    reg  [1:0]  kind_reg;
    reg  [1:0]  last_kind_reg;
    reg         dest_reg;
    reg  [7:0]  operand_reg;
    reg  [7:0]  result_reg;
    reg  [4:0]  flags_hold_reg;
    reg  [4:0]  flags_next;
    reg  [7:0]  result_next;
    reg  [8:0]  sum_full;
    reg  [4:0]  sum_low;
    reg  [7:0]  addend;
    reg         carry_in;
    wire [1:0]  kind_next;
    wire        bus_ack;
    wire        bus_wr;
    wire [31:0] read_value;

    // Classifies an instruction word into one of the three adds, or none.
    function [1:0] add_kind;
        input [15:0] word;
        begin
            if (word[15:8] == `AIE_OPC_LIT) begin
                add_kind = `AIE_KIND_LIT; // [RULE7]
            end else if (word[15:10] == `AIE_OPC_ADDF) begin
                add_kind = `AIE_KIND_ADDF; // [RULE1]
            end else if (word[15:10] == `AIE_OPC_ADDC) begin
                add_kind = `AIE_KIND_ADDC; // [RULE4]
            end else begin
                add_kind = `AIE_KIND_NONE;
            end
        end
    endfunction

    // Resolves the 8-bit operand field and bank bit into a data memory address.
    function [11:0] file_address;
        input [7:0]  f;
        input        a;
        input [3:0]  bank;
        input        ext;
        input [11:0] base;
        begin
            if (a) begin
                file_address = {bank, f}; // [RULE2]
            end else if (ext && (f <= `AIE_ACCESS_LIMIT)) begin
                file_address = base + {4'h0, f}; // [RULE3]
            end else if (f <= `AIE_ACCESS_LIMIT) begin
                file_address = {4'h0, f}; // [RULE2]
            end else begin
                file_address = {`AIE_ACCESS_HI_BANK, f}; // [RULE2]
            end
        end
    endfunction

    // Reads the value a register offset shows; unmapped offsets read zero.
    function [31:0] reg_view;
        input [7:0] ofs;
        input [7:0] acc;
        input [4:0] flags;
        input [3:0] bank;
        input       ext;
        input [11:0] base;
        input       busy;
        input [1:0] last;
        input [7:0] res;
        begin
            case (ofs)
                `AIE_OFS_ACC:     reg_view = {24'h000000, acc};
                `AIE_OFS_FLAGS:   reg_view = {27'h0000000, flags};
                `AIE_OFS_BANK:    reg_view = {28'h0000000, bank};
                `AIE_OFS_CTRL:    reg_view = {31'h00000000, ext};
                `AIE_OFS_IDXBASE: reg_view = {20'h00000, base};
                `AIE_OFS_EXEC:    reg_view = {16'h0000, res, 5'h00, last, busy};
                default:          reg_view = 32'h00000000;
            endcase
        end
    endfunction

    assign kind_next  = add_kind(INSTR);
    // A request completes at the edge where waitrequest is seen low.
    assign bus_ack    = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    assign bus_wr     = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    assign read_value = reg_view(AVS_ADDRESS, acc_reg, flags_reg, bank_reg, ext_reg,
                                 idxbase_reg, busy_reg, last_kind_reg, result_reg);

    // Arithmetic for all three adds, formed during the processing quarter.
    always @* begin
        if (kind_reg == `AIE_KIND_LIT) begin
            addend = operand_reg;
        end else begin
            addend = DMEM_RDATA;
        end
        if (kind_reg == `AIE_KIND_ADDC) begin
            carry_in = flags_reg[`AIE_FLG_C]; // [RULE4]
        end else begin
            carry_in = 1'b0;
        end
        sum_full    = {1'b0, acc_reg} + {1'b0, addend} + {8'h00, carry_in}; // [RULE1] [RULE4] [RULE7]
        sum_low     = {1'b0, acc_reg[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};
        result_next = sum_full[7:0];
        flags_next  = flags_reg;
        flags_next[`AIE_FLG_C]  = sum_full[8]; // [RULE8]
        flags_next[`AIE_FLG_DC] = sum_low[4]; // [RULE8]
        flags_next[`AIE_FLG_Z]  = (sum_full[7:0] == 8'h00); // [RULE8]
        flags_next[`AIE_FLG_N]  = sum_full[7]; // [RULE8]
        flags_next[`AIE_FLG_OV] = (acc_reg[7] == addend[7]) && (sum_full[7] != acc_reg[7]); // [RULE8]
    end

    // Quarter sequencer and datapath. One instruction per four clocks.
    always @(posedge CLK) begin
        if (RST) begin
            QUARTER       <= `AIE_Q1;
            EXEC_DONE     <= 1'b0;
            DMEM_ADDR     <= 12'h000;
            DMEM_RD       <= 1'b0;
            DMEM_WR       <= 1'b0;
            DMEM_WDATA    <= 8'h00;
            busy_reg      <= 1'b0;
            kind_reg      <= `AIE_KIND_NONE;
            last_kind_reg <= `AIE_KIND_NONE;
            dest_reg      <= 1'b0;
            operand_reg   <= 8'h00;
            result_reg    <= 8'h00;
            flags_hold_reg <= `AIE_RST_FLAGS;
        end else begin
            QUARTER   <= QUARTER + 2'h1; // [RULE6]
            EXEC_DONE <= 1'b0;
            case (QUARTER)
                `AIE_Q1: begin
                    // Decode; the operand address goes out for the read quarter.
                    busy_reg <= INSTR_VALID && (kind_next != `AIE_KIND_NONE); // [RULE6]
                    kind_reg <= INSTR_VALID ? kind_next : `AIE_KIND_NONE;
                    dest_reg <= INSTR[9]; // [RULE1] [RULE5]
                    operand_reg <= INSTR[7:0];
                    DMEM_ADDR <= file_address(INSTR[7:0], INSTR[8], bank_reg, ext_reg,
                                              idxbase_reg);
                    DMEM_RD   <= INSTR_VALID && ((kind_next == `AIE_KIND_ADDF) ||
                                                 (kind_next == `AIE_KIND_ADDC)); // [RULE6]
                end
                `AIE_Q2: begin
                    DMEM_RD <= 1'b0;
                end
                `AIE_Q3: begin
                    // The memory answers one clock after the read strobe.
                    if (busy_reg) begin
                        result_reg <= result_next; // [RULE6]
                        flags_hold_reg <= flags_next; // [RULE8]
                        DMEM_WDATA <= result_next;
                        DMEM_WR    <= dest_reg && (kind_reg != `AIE_KIND_LIT); // [RULE1] [RULE5]
                    end
                end
                default: begin
                    DMEM_WR <= 1'b0;
                    if (busy_reg) begin
                        EXEC_DONE     <= 1'b1;
                        last_kind_reg <= kind_reg;
                    end
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Accumulator and flags: the write quarter of an add wins over software.
    // Flags are captured with the sum in Q3, because memory data need not stand in Q4.
    always @(posedge CLK) begin
        if (RST) begin
            acc_reg   <= `AIE_RST_ACC;
            flags_reg <= `AIE_RST_FLAGS;
        end else begin
            if (busy_reg && (QUARTER == `AIE_Q4)) begin
                flags_reg <= flags_hold_reg; // [RULE8]
                if ((kind_reg == `AIE_KIND_LIT) || !dest_reg) begin
                    acc_reg <= result_reg; // [RULE1] [RULE5] [RULE7]
                end else if (bus_wr && (AVS_ADDRESS == `AIE_OFS_ACC)) begin
                    acc_reg <= AVS_WRITEDATA[7:0];
                end
            end else if (bus_wr && (AVS_ADDRESS == `AIE_OFS_ACC)) begin
                acc_reg <= AVS_WRITEDATA[7:0];
            end else if (bus_wr && (AVS_ADDRESS == `AIE_OFS_FLAGS)) begin
                flags_reg <= AVS_WRITEDATA[4:0];
            end
        end
    end

    // Configuration registers written only by software.
    always @(posedge CLK) begin
        if (RST) begin
            bank_reg    <= `AIE_RST_BANK;
            ext_reg     <= `AIE_RST_CTRL;
            idxbase_reg <= `AIE_RST_IDXBASE;
        end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
            if (AVS_BYTEENABLE[0]) begin
                if (AVS_ADDRESS == `AIE_OFS_BANK) begin
                    bank_reg <= AVS_WRITEDATA[3:0];
                end
                if (AVS_ADDRESS == `AIE_OFS_CTRL) begin
                    ext_reg <= AVS_WRITEDATA[`AIE_CTRL_EXT];
                end
                if (AVS_ADDRESS == `AIE_OFS_IDXBASE) begin
                    idxbase_reg[7:0] <= AVS_WRITEDATA[7:0];
                end
            end
            if (AVS_BYTEENABLE[1] && (AVS_ADDRESS == `AIE_OFS_IDXBASE)) begin
                idxbase_reg[11:8] <= AVS_WRITEDATA[11:8];
            end
        end
    end

    // Avalon slave: one wait cycle per access, then a single low cycle.
    always @(posedge CLK) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= 32'h00000000;
        end else if (bus_ack) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (AVS_READ || AVS_WRITE) begin
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? read_value : 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= 1'b1;
        end
    end

endmodule // aie_core

/* File: hdl/aie_defs.vh */
// Constants for the add instruction execution block.
//
// Function
// [RULE1] The register add opcode adds the accumulator to the addressed file register and writes the sum to the accumulator when the destination bit is 0, else back to the file register.
// [RULE2] With the bank bit 0 the operand comes from the access bank, with it 1 the bank select pointer picks the general purpose file bank.
// [RULE3] With the bank bit 0 and the extended set enabled, operand addresses up to 95 use indexed literal offset addressing instead of the access bank.
// [RULE4] The add-with-carry opcode sums the accumulator, the file register and the current carry flag as one result.
// [RULE5] The add-with-carry result goes to the accumulator when the destination bit is 0 and to the file register when it is 1.
// [RULE6] The register add completes in one four-quarter cycle: decode, operand read, process, write to destination.
// [RULE7] The literal add opcode adds its low-byte literal to the accumulator in one cycle and updates all five arithmetic flags.
// [RULE8] Every add updates the negative, signed wrap, carry, half byte carry and zero flags from the result and its carries.
`ifndef AIE_DEFS_VH
`define AIE_DEFS_VH

`define AIE_OFS_ACC         8'h00
`define AIE_OFS_FLAGS       8'h04
`define AIE_OFS_BANK        8'h08
`define AIE_OFS_CTRL        8'h0c
`define AIE_OFS_IDXBASE     8'h10
`define AIE_OFS_EXEC        8'h14

`define AIE_FLG_C           0
`define AIE_FLG_DC          1
`define AIE_FLG_Z           2
`define AIE_FLG_OV          3
`define AIE_FLG_N           4
`define AIE_CTRL_EXT        0

`define AIE_RST_ACC         8'h00
`define AIE_RST_FLAGS       5'h00
`define AIE_RST_BANK        4'h0
`define AIE_RST_CTRL        1'b0
`define AIE_RST_IDXBASE     12'h000

`define AIE_OPC_LIT         8'h0f
`define AIE_OPC_ADDF        6'h09
`define AIE_OPC_ADDC        6'h08

`define AIE_ACCESS_LIMIT    8'h5f
`define AIE_ACCESS_HI_BANK  4'hf

`define AIE_Q1              2'h0
`define AIE_Q2              2'h1
`define AIE_Q3              2'h2
`define AIE_Q4              2'h3

`define AIE_KIND_NONE       2'h0
`define AIE_KIND_LIT        2'h1
`define AIE_KIND_ADDF       2'h2
`define AIE_KIND_ADDC       2'h3

`endif

/* File: test/aie_core_chk.sv */
// Port-level assertions for the add execution unit.
`timescale 1ns/10ps
module aie_chk (
    input wire        CLK,
    input wire        RST,
    input wire        INSTR_VALID,
    input wire [15:0] INSTR,
    input wire [1:0]  QUARTER,
    input wire        EXEC_DONE,
    input wire [11:0] DMEM_ADDR,
    input wire        DMEM_RD,
    input wire        DMEM_WR,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire        AVS_WAITREQUEST
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire q1 = QUARTER == 2'h0 && INSTR_VALID;
    wire fa = q1 && INSTR[15:11] == 5'h04;
    wire la = q1 && INSTR[15:8] == 8'h0f;
    quarter_step_a: assert property (1 |=> QUARTER == $past(QUARTER) + 2'h1)
        else $error("quarter count skipped");
    read_in_q2_a: assert property (DMEM_RD |-> QUARTER == 2'h1)
        else $error("operand read outside second quarter");
    file_read_a: assert property (fa |=> DMEM_RD)
        else $error("file add without operand read");
    dest_write_a: assert property (fa |-> ##3 DMEM_WR == $past(INSTR[9], 3))
        else $error("memory write does not follow destination bit");
    done_pulse_a: assert property (fa || la |-> ##4 EXEC_DONE ##1 !EXEC_DONE)
        else $error("completion pulse misplaced");
    lit_quiet_a: assert property (la |=> !DMEM_RD ##2 !DMEM_WR)
        else $error("literal add touched memory");
    high_addr_a: assert property (fa && !INSTR[8] && INSTR[7:0] > 8'h5f
        |=> DMEM_ADDR == {4'hf, $past(INSTR[7:0])}) else $error("access bank high half wrong");
    bus_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("wait cycle count wrong");
    cover property (fa && INSTR[9]);
    cover property (fa && !INSTR[10]);
    cover property (la);
endmodule // aie_chk
bind aie_core aie_chk u_chk (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .QUARTER(QUARTER), .EXEC_DONE(EXEC_DONE), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD),
    .DMEM_WR(DMEM_WR), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST));

/* File: test/aie_core_tb.sv */
// Directed bench for the add execution unit.
`timescale 1ns/10ps
module aie_core_tb;
    reg         CLK = 1'b0;
    reg         RST = 1'b1;
    reg         INSTR_VALID = 1'b0;
    reg  [15:0] INSTR = 16'h0000;
    reg  [7:0]  DMEM_RDATA = 8'h00;
    reg  [7:0]  AVS_ADDRESS = 8'h00;
    reg         AVS_READ = 1'b0;
    reg         AVS_WRITE = 1'b0;
    reg  [31:0] AVS_WRITEDATA = 32'h0;
    wire [1:0]  QUARTER;
    wire        EXEC_DONE, DMEM_RD, DMEM_WR, AVS_WAITREQUEST;
    wire [11:0] DMEM_ADDR;
    wire [7:0]  DMEM_WDATA;
    wire [31:0] AVS_READDATA;
    integer     mismatches = 0;
    integer     samples_checked = 0;
    integer     i;
    reg  [31:0] q;
    aie_core uut (.CLK(CLK), .RST(RST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
        .QUARTER(QUARTER), .EXEC_DONE(EXEC_DONE), .DMEM_ADDR(DMEM_ADDR), .DMEM_RD(DMEM_RD),
        .DMEM_RDATA(DMEM_RDATA), .DMEM_WR(DMEM_WR), .DMEM_WDATA(DMEM_WDATA),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST));
    task report_and_stop;
        begin
            $display("compares %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Entered just after a rising edge; returns one edge after the edge that took the answer.
    task bus(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            AVS_READ <= !w;
            AVS_WRITE <= w;
            AVS_ADDRESS <= a;
            AVS_WRITEDATA <= d;
            n = 0;
            @(posedge CLK);
            while (AVS_WAITREQUEST !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    chk(1, 0);
                    report_and_stop;
                end
                @(posedge CLK);
            end
            q = AVS_READDATA;
            AVS_READ <= 1'b0;
            AVS_WRITE <= 1'b0;
            @(posedge CLK);
        end
    endtask
    // Packs {N, signed wrap, Z, half byte carry, C, sum}.
    function [12:0] add8(input [7:0] a, input [7:0] b, input c);
        reg [8:0] s;
        reg [4:0] h;
        begin
            s = a + b + c;
            h = a[3:0] + b[3:0] + c;
            add8 = {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4], s[8], s[7:0]};
        end
    endfunction
    task op(input [15:0] w, input [7:0] acc, input cin, input [7:0] rd, input [11:0] ea);
        reg        lit, fil;
        reg [12:0] r;
        integer    n;
        begin
            lit = w[15:8] == 8'h0f;
            fil = w[15:11] == 5'h04;
            r = add8(acc, lit ? w[7:0] : rd, fil & !w[10] & cin);
            bus(1, 8'h00, acc);
            bus(1, 8'h04, cin);
            for (n = 0; QUARTER !== 2'h3 && n < 8; n = n + 1)
                @(posedge CLK);
            if (n >= 8) begin
                chk(1, 0);
                report_and_stop;
            end
            INSTR_VALID <= 1'b1;
            INSTR <= w;
            @(posedge CLK);
            INSTR_VALID <= 1'b0;
            DMEM_RDATA <= rd;
            #1;
            chk(DMEM_RD, fil);
            if (fil) chk(DMEM_ADDR, ea);
            @(posedge CLK);
            #1;
            chk(DMEM_RD, 0);
            @(posedge CLK);
            DMEM_RDATA <= ~rd;
            #1;
            chk(DMEM_WR, fil & w[9]);
            if (fil & w[9]) chk(DMEM_WDATA, r[7:0]);
            @(posedge CLK);
            #1;
            chk(EXEC_DONE, lit | fil);
            @(posedge CLK);
            bus(0, 8'h00, 0);
            chk(q, lit | fil & !w[9] ? r[7:0] : acc);
            bus(0, 8'h04, 0);
            chk(q, lit | fil ? r[12:8] : cin);
            if (lit | fil) begin
                bus(0, 8'h14, 0);
                chk(q, {16'h0000, r[7:0], 5'h00, lit ? 2'h1 : {1'b1, !w[10]}, 1'b0});
            end
        end
    endtask
    initial begin
        forever #5 CLK = ~CLK;
    end
    initial begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        for (i = 0; i < 7; i = i + 1) begin
            bus(0, i * 4, 0);
            chk(q, 0);
        end
        bus(1, 8'h18, 32'hffffffff);
        bus(0, 8'h18, 0);
        chk(q, 0);
        $display("test reset values done");
        op(16'h0f15, 8'h10, 1'b1, 8'h00, 12'h000);
        op(16'h0f01, 8'h7f, 1'b0, 8'h00, 12'h000);
        op(16'h0f01, 8'hff, 1'b0, 8'h00, 12'h000);
        op(16'h0f88, 8'h88, 1'b1, 8'h00, 12'h000);
        op(16'h0f08, 8'h08, 1'b0, 8'h00, 12'h000);
        $display("test literal add done");
        bus(1, 8'h08, 3);
        bus(1, 8'h10, 32'h123);
        op(16'h2544, 8'h20, 1'b1, 8'h30, 12'h344);
        op(16'h2680, 8'hf0, 1'b0, 8'h20, 12'hf80);
        op(16'h2010, 8'h7f, 1'b1, 8'h00, 12'h010);
        bus(1, 8'h0c, 1);
        op(16'h225f, 8'h02, 1'b1, 8'h4d, 12'h182);
        op(16'h2260, 8'h80, 1'b1, 8'h80, 12'hf60);
        op(16'h2360, 8'h01, 1'b1, 8'hfe, 12'h360);
        op(16'h1400, 8'h55, 1'b1, 8'h00, 12'h000);
        $display("test file add done");
        report_and_stop;
    end
endmodule // aie_core_tb
